// *** hdl/cbsu_pkg.sv ***
// Package: constants, layouts and state type of the compare/skip/branch unit
package cbsu_pkg;

  // Register byte offsets
  localparam logic [7:0] CMD_OFS    = 8'h00;
  localparam logic [7:0] OPND_OFS   = 8'h04;
  localparam logic [7:0] FLAG_OFS   = 8'h08;
  localparam logic [7:0] PC_OFS     = 8'h0c;
  localparam logic [7:0] STAT_OFS   = 8'h10;

  // Command register fields
  localparam int OP_LSB     = 0;
  localparam int BIT_LSB    = 4;
  localparam int OFS_LSB    = 8;
  localparam int LONG_POS   = 16;
  localparam int CMD_W      = 17;

  // Operand register fields
  localparam int RD_LSB     = 0;
  localparam int RR_LSB     = 8;
  localparam int IO_LSB     = 16;
  localparam int OPND_W     = 24;

  // Flag positions inside core_flag_register
  localparam int FLAG_C     = 0;
  localparam int FLAG_Z     = 1;
  localparam int FLAG_N     = 2;
  localparam int FLAG_V     = 3;
  localparam int FLAG_S     = 4;
  localparam int FLAG_H     = 5;

  // Status register fields
  localparam int ST_BUSY    = 0;
  localparam int ST_TAKEN   = 1;
  localparam int ST_ILLEGAL = 2;
  localparam int ST_CYC_LSB = 8;

  // Operation codes
  localparam logic [3:0] OP_CMP_SKIP_IF_EQUAL     = 4'h0;
  localparam logic [3:0] OP_CMP_REGS              = 4'h1;
  localparam logic [3:0] OP_CMP_REGS_WITH_CARRY   = 4'h2;
  localparam logic [3:0] OP_CMP_IMMEDIATE         = 4'h3;
  localparam logic [3:0] OP_SKIP_REG_BIT_CLEAR    = 4'h4;
  localparam logic [3:0] OP_SKIP_REG_BIT_SET      = 4'h5;
  localparam logic [3:0] OP_SKIP_IO_BIT_CLEAR     = 4'h6;
  localparam logic [3:0] OP_SKIP_IO_BIT_SET       = 4'h7;
  localparam logic [3:0] OP_BRANCH_FLAG_SET       = 4'h8;
  localparam logic [3:0] OP_BRANCH_FLAG_CLEAR     = 4'h9;
  localparam logic [3:0] OP_BRANCH_EQUAL          = 4'ha;
  localparam logic [3:0] OP_BRANCH_NOT_EQUAL      = 4'hb;
  localparam logic [3:0] OP_BRANCH_CARRY_SET      = 4'hc;
  localparam logic [3:0] OP_BRANCH_CARRY_CLEAR    = 4'hd;
  localparam logic [3:0] OP_BRANCH_SAME_OR_HIGHER = 4'he;

  // Cycle costs and program counter steps
  localparam logic [1:0]  CYC_ONE    = 2'h1;
  localparam logic [1:0]  CYC_TWO    = 2'h2;
  localparam logic [1:0]  CYC_THREE  = 2'h3;
  localparam logic [15:0] PC_STEP    = 16'h0001;
  localparam logic [15:0] SKIP_SHORT = 16'h0002;
  localparam logic [15:0] SKIP_LONG  = 16'h0003;

  // Reset values
  localparam logic [15:0] PC_RST   = 16'h0000;
  localparam logic [7:0]  FLAG_RST = 8'h00;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [0:0] {
    CBSU_IDLE,
    CBSU_EXEC
  } cbsu_fsm_t;

  typedef struct packed {
    cbsu_fsm_t           fsm;
    logic [1:0]          cnt;
    logic [15:0]         pc;
    logic [7:0]          flags;
    logic [OPND_W-1:0]   opnds;
    logic [CMD_W-1:0]    cmd;
    logic [15:0]         pc_pend;
    logic [7:0]          flags_pend;
    logic                taken;
    logic                illegal;
    logic [1:0]          last_cycles;
    logic                retire;
    logic                aw_held;
    logic [7:0]          aw_addr;
    logic                w_held;
    logic [31:0]         w_data;
    logic [3:0]          w_strb;
    logic                bvalid;
    logic [1:0]          bresp;
    logic                rvalid;
    logic [31:0]         rdata;
    logic [1:0]          rresp;
  } cbsu_state_t;

endpackage

// *** hdl/cbsu_unit.sv ***
// Compare, skip and branch execution unit with an AXI4-Lite register port
// Notes on behaviour
// - cmp_skip_if_equal skips the next instruction on equal registers, in 1, 2 or 3 cycles.
// - Compares subtract source, carry or immediate from Rd and set flags only, in 1 cycle.
// - Register-bit skips skip on a clear or set bit of a register, in 1, 2 or 3 cycles.
// - I/O-bit skips skip on a clear or set bit of an I/O register, in 1, 2 or 3 cycles.
// - Flag branches load PC plus offset plus one on a set or clear flag, in 1 or 2 cycles.
// - The carry branches jump when carry is one or zero, costing 1 or 2 cycles.
// - The same-or-higher branch jumps when carry is zero, costing 1 or 2 cycles.
//
// Our own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none

module cbsu_unit (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [15:0]      pc,
  output logic [7:0]       core_flag_register,
  output logic             retire
);

  cbsu_pkg::cbsu_state_t st;
  cbsu_pkg::cbsu_state_t next_st;

  // Byte-lane merge of a write into a register image
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return (a == cbsu_pkg::CMD_OFS) || (a == cbsu_pkg::OPND_OFS) ||
           (a == cbsu_pkg::FLAG_OFS) || (a == cbsu_pkg::PC_OFS) ||
           (a == cbsu_pkg::STAT_OFS);
  endfunction

  // Operand and command fields
  logic [3:0]  op;
  logic [2:0]  bsel;
  logic [6:0]  koff;
  logic        long_next;
  logic [7:0]  rd;
  logic [7:0]  rr;
  logic [7:0]  io_val;

  assign op        = st.cmd[cbsu_pkg::OP_LSB +: 4];
  assign bsel      = st.cmd[cbsu_pkg::BIT_LSB +: 3];
  assign koff      = st.cmd[cbsu_pkg::OFS_LSB +: 7];
  assign long_next = st.cmd[cbsu_pkg::LONG_POS];
  assign rd        = st.opnds[cbsu_pkg::RD_LSB +: 8];
  assign rr        = st.opnds[cbsu_pkg::RR_LSB +: 8];
  assign io_val    = st.opnds[cbsu_pkg::IO_LSB +: 8];

  // Result of the command held in st.cmd
  logic [15:0] x_pc;
  logic [7:0]  x_flags;
  logic [1:0]  x_cyc;
  logic        x_taken;
  logic        x_illegal;

  always_comb begin
    logic [7:0]  sub;
    logic [7:0]  res;
    logic        cin;
    logic        is_cmp;
    logic        skip;
    logic        br;
    logic        is_br;
    logic [15:0] kext;
    sub       = rr;
    res       = 8'h00;
    cin       = 1'b0;
    is_cmp    = 1'b0;
    skip      = 1'b0;
    br        = 1'b0;
    is_br     = 1'b0;
    x_illegal = 1'b0;
    kext      = {{9{koff[6]}}, koff};
    unique case (op)
      cbsu_pkg::OP_CMP_SKIP_IF_EQUAL:     skip = (rd == rr);
      cbsu_pkg::OP_CMP_REGS:              is_cmp = 1'b1;
      cbsu_pkg::OP_CMP_REGS_WITH_CARRY: begin
        is_cmp = 1'b1;
        cin    = st.flags[cbsu_pkg::FLAG_C];
      end
      cbsu_pkg::OP_CMP_IMMEDIATE:         is_cmp = 1'b1;
      cbsu_pkg::OP_SKIP_REG_BIT_CLEAR:    skip = ~rr[bsel];
      cbsu_pkg::OP_SKIP_REG_BIT_SET:      skip = rr[bsel];
      cbsu_pkg::OP_SKIP_IO_BIT_CLEAR:     skip = ~io_val[bsel];
      cbsu_pkg::OP_SKIP_IO_BIT_SET:       skip = io_val[bsel];
      cbsu_pkg::OP_BRANCH_FLAG_SET: begin
        is_br = 1'b1;
        br    = st.flags[bsel];
      end
      cbsu_pkg::OP_BRANCH_FLAG_CLEAR: begin
        is_br = 1'b1;
        br    = ~st.flags[bsel];
      end
      cbsu_pkg::OP_BRANCH_EQUAL: begin
        is_br = 1'b1;
        br    = st.flags[cbsu_pkg::FLAG_Z];
      end
      cbsu_pkg::OP_BRANCH_NOT_EQUAL: begin
        is_br = 1'b1;
        br    = ~st.flags[cbsu_pkg::FLAG_Z];
      end
      cbsu_pkg::OP_BRANCH_CARRY_SET: begin
        is_br = 1'b1;
        br    = st.flags[cbsu_pkg::FLAG_C];
      end
      cbsu_pkg::OP_BRANCH_CARRY_CLEAR: begin
        is_br = 1'b1;
        br    = ~st.flags[cbsu_pkg::FLAG_C];
      end
      cbsu_pkg::OP_BRANCH_SAME_OR_HIGHER: begin
        is_br = 1'b1;
        br    = ~st.flags[cbsu_pkg::FLAG_C];
      end
      default: x_illegal = 1'b1;
    endcase

    // Subtraction for the compare forms; register file is never written
    res     = 8'(rd - sub - {7'h00, cin});
    x_flags = st.flags;
    if (is_cmp) begin
      x_flags[cbsu_pkg::FLAG_H] = (~rd[3] & sub[3]) | (sub[3] & res[3]) | (res[3] & ~rd[3]);
      x_flags[cbsu_pkg::FLAG_V] = (rd[7] & ~sub[7] & ~res[7]) | (~rd[7] & sub[7] & res[7]);
      x_flags[cbsu_pkg::FLAG_N] = res[7];
      x_flags[cbsu_pkg::FLAG_S] = res[7] ^ x_flags[cbsu_pkg::FLAG_V];
      x_flags[cbsu_pkg::FLAG_C] = (~rd[7] & sub[7]) | (sub[7] & res[7]) | (res[7] & ~rd[7]);
      // With-carry form keeps Z only while the result stays zero
      if (op == cbsu_pkg::OP_CMP_REGS_WITH_CARRY) begin
        x_flags[cbsu_pkg::FLAG_Z] = (res == 8'h00) & st.flags[cbsu_pkg::FLAG_Z];
      end else begin
        x_flags[cbsu_pkg::FLAG_Z] = (res == 8'h00);
      end
    end

    // Program counter and cycle cost
    x_taken = skip | br;
    x_pc    = st.pc + cbsu_pkg::PC_STEP;
    x_cyc   = cbsu_pkg::CYC_ONE;
    if (skip) begin
      x_pc  = st.pc + (long_next ? cbsu_pkg::SKIP_LONG : cbsu_pkg::SKIP_SHORT);
      x_cyc = long_next ? cbsu_pkg::CYC_THREE : cbsu_pkg::CYC_TWO;
    end else if (is_br && br) begin
      x_pc  = st.pc + kext + cbsu_pkg::PC_STEP;
      x_cyc = cbsu_pkg::CYC_TWO;
    end
    if (x_illegal) begin
      x_pc = st.pc;
    end
  end

  // Register read image
  function automatic logic [31:0] read_reg(input cbsu_pkg::cbsu_state_t s,
                                           input logic [7:0] a);
    logic [31:0] r;
    r = 32'h0000_0000;
    unique case (a)
      cbsu_pkg::CMD_OFS:  r = {15'h0000, s.cmd};
      cbsu_pkg::OPND_OFS: r = {8'h00, s.opnds};
      cbsu_pkg::FLAG_OFS: r = {24'h00_0000, s.flags};
      cbsu_pkg::PC_OFS:   r = {16'h0000, s.pc};
      cbsu_pkg::STAT_OFS: begin
        r[cbsu_pkg::ST_BUSY]          = (s.fsm == cbsu_pkg::CBSU_EXEC);
        r[cbsu_pkg::ST_TAKEN]         = s.taken;
        r[cbsu_pkg::ST_ILLEGAL]       = s.illegal;
        r[cbsu_pkg::ST_CYC_LSB +: 2]  = s.last_cycles;
      end
      default: r = 32'h0000_0000;
    endcase
    return r;
  endfunction

  logic        aw_take;
  logic        w_take;
  logic        ar_take;
  logic        do_wr;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;

  assign s_axi_awready = ~st.aw_held & ~st.bvalid;
  assign s_axi_wready  = ~st.w_held & ~st.bvalid;
  assign s_axi_arready = ~st.rvalid;
  assign aw_take       = s_axi_awvalid & s_axi_awready;
  assign w_take        = s_axi_wvalid & s_axi_wready;
  assign ar_take       = s_axi_arvalid & s_axi_arready;
  assign do_wr         = (st.aw_held | aw_take) & (st.w_held | w_take) & ~st.bvalid;
  assign wr_addr       = st.aw_held ? st.aw_addr : {s_axi_awaddr[7:2], 2'b00};
  assign wr_data       = st.w_held ? st.w_data : s_axi_wdata;
  assign wr_strb       = st.w_held ? st.w_strb : s_axi_wstrb;

  always_comb begin
    logic busy;
    next_st        = st;
    next_st.retire = 1'b0;
    busy           = (st.fsm == cbsu_pkg::CBSU_EXEC);

    // Write address and data may arrive in either order
    if (aw_take) begin
      next_st.aw_held = 1'b1;
      next_st.aw_addr = {s_axi_awaddr[7:2], 2'b00};
    end
    if (w_take) begin
      next_st.w_held = 1'b1;
      next_st.w_data = s_axi_wdata;
      next_st.w_strb = s_axi_wstrb;
    end
    if (do_wr) begin
      next_st.aw_held = 1'b0;
      next_st.w_held  = 1'b0;
      next_st.bvalid  = 1'b1;
      next_st.bresp   = mapped(wr_addr) ? cbsu_pkg::RESP_OKAY : cbsu_pkg::RESP_SLVERR;
      // State writes are dropped while an instruction is in flight
      if (!busy) begin
        unique case (wr_addr)
          cbsu_pkg::CMD_OFS: begin
            next_st.cmd = cbsu_pkg::CMD_W'(merge({15'h0000, st.cmd}, wr_data, wr_strb));
            next_st.fsm = cbsu_pkg::CBSU_EXEC;
            next_st.cnt = 2'h0;
          end
          cbsu_pkg::OPND_OFS:
            next_st.opnds = cbsu_pkg::OPND_W'(merge({8'h00, st.opnds}, wr_data, wr_strb));
          cbsu_pkg::FLAG_OFS:
            next_st.flags = 8'(merge({24'h00_0000, st.flags}, wr_data, wr_strb));
          cbsu_pkg::PC_OFS:
            next_st.pc = 16'(merge({16'h0000, st.pc}, wr_data, wr_strb));
          default: next_st.bresp = next_st.bresp;
        endcase
      end
    end else if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end

    if (ar_take) begin
      next_st.rvalid = 1'b1;
      next_st.rdata  = read_reg(st, {s_axi_araddr[7:2], 2'b00});
      next_st.rresp  = mapped({s_axi_araddr[7:2], 2'b00}) ? cbsu_pkg::RESP_OKAY
                                                          : cbsu_pkg::RESP_SLVERR;
    end else if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end

    // Instruction occupies its cycle cost, then commits PC and flags
    if (busy) begin
      if (st.cnt == 2'h0) begin
        next_st.pc_pend     = x_pc;
        next_st.flags_pend  = x_flags;
        next_st.taken       = x_taken;
        next_st.illegal     = x_illegal;
        next_st.last_cycles = x_cyc;
      end
      if ((st.cnt == 2'h0 ? x_cyc : st.last_cycles) == 2'(st.cnt + 2'h1)) begin
        next_st.fsm    = cbsu_pkg::CBSU_IDLE;
        next_st.pc     = (st.cnt == 2'h0) ? x_pc : st.pc_pend;
        next_st.flags  = (st.cnt == 2'h0) ? x_flags : st.flags_pend;
        next_st.retire = 1'b1;
        next_st.cnt    = 2'h0;
      end else begin
        next_st.cnt = 2'(st.cnt + 2'h1);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st             <= '0;
      st.fsm         <= cbsu_pkg::CBSU_IDLE;
      st.pc          <= cbsu_pkg::PC_RST;
      st.flags       <= cbsu_pkg::FLAG_RST;
    end else begin
      st <= next_st;
    end
  end

  assign s_axi_bvalid       = st.bvalid;
  assign s_axi_bresp        = st.bresp;
  assign s_axi_rvalid       = st.rvalid;
  assign s_axi_rdata        = st.rdata;
  assign s_axi_rresp        = st.rresp;
  assign pc                 = st.pc;
  assign core_flag_register = st.flags;
  assign retire             = st.retire;

endmodule

`default_nettype wire

// *** test/cbsu_unit_sva.sv ***
// Port-level assertions for the compare/skip/branch unit
`timescale 1ns/10ps
`default_nettype none
module cbsu_unit_chk (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [15:0] pc,
  input wire logic [7:0]  core_flag_register,
  input wire logic        retire
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer not held");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer not held");
  property p_w_block;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_w_block: assert property (p_w_block) else $error("write taken during answer");
  property p_ar_block;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar_block: assert property (p_ar_block) else $error("read taken during answer");
  property p_retire_pulse;
    retire |=> !retire;
  endproperty
  a_retire_pulse: assert property (p_retire_pulse) else $error("retire too long");
  property p_retire_due;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      && s_axi_awaddr[7:2] == 6'h00 |-> ##[2:4] retire;
  endproperty
  a_retire_due: assert property (p_retire_due) else $error("instruction overran");
  property p_pc_quiet;
    $past(aresetn) && !$stable(pc) |-> retire || s_axi_bvalid;
  endproperty
  a_pc_quiet: assert property (p_pc_quiet) else $error("pc moved unasked");
  property p_flag_quiet;
    $past(aresetn) && !$stable(core_flag_register) |-> retire || s_axi_bvalid;
  endproperty
  a_flag_quiet: assert property (p_flag_quiet) else $error("flags moved unasked");
endmodule
`default_nettype wire

// *** test/testbench.sv ***
// Self-checking bench for the compare/skip/branch unit
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'hf;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, retire;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [15:0] pc;
  logic [7:0]  flags;
  logic [31:0] seed = 32'hf6b318dd;
  int          num_errors = 0, check_count = 0, cyc = 0, launch = 0, ret_cyc = -1;
  always #2 aclk = ~aclk;
  always @(posedge aclk) cyc <= cyc + 1;
  always @(negedge aclk) if (retire === 1'b1) ret_cyc = cyc;
  cbsu_unit u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .pc(pc), .core_flag_register(flags), .retire(retire));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic complete_run();
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bound(input int n);
    if (n > 40) begin
      chk(32'h1, 32'h0);
      complete_run();
    end
  endtask
  // Raises ready after a random stall, returns once the answer stands
  task automatic answer(input bit rs);
    int n, stall;
    stall = rnd() % 3;
    repeat (stall) @(posedge aclk);
    if (rs) begin
      rready <= 1'b1;
    end else begin
      bready <= 1'b1;
    end
    n = 0;
    do begin
      @(negedge aclk);
      bound(n++);
    end while ((rs ? rvalid : bvalid) !== 1'b1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw, w;
    int n;
    @(posedge aclk);
    aw = 1'b0;
    w = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (n = 0; !(aw && w); n++) begin
      bound(n);
      @(negedge aclk);
      aw = aw || (awvalid && awready === 1'b1);
      w = w || (wvalid && wready === 1'b1);
      if (aw && w) launch = cyc;
      @(posedge aclk);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
    end
    answer(1'b0);
    r = bresp;
    @(posedge aclk);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    n = 0;
    do begin
      @(negedge aclk);
      bound(n++);
    end while (arready !== 1'b1);
    @(posedge aclk);
    arvalid <= 1'b0;
    answer(1'b1);
    d = rdata;
    r = rresp;
    @(posedge aclk);
    rready <= 1'b0;
  endtask
  // Expected {taken, cycles, flags, pc} of one instruction
  function automatic logic [26:0] model(input logic [3:0] op, input logic [2:0] b,
      input logic [6:0] k, input logic lg, input logic [23:0] o, input logic [7:0] f,
      input logic [15:0] p0);
    logic tk, ci;
    logic [1:0] cy;
    logic [7:0] nf, rs, d, s;
    int sd;
    d = o[7:0];
    s = o[15:8];
    nf = f;
    tk = 1'b0;
    ci = (op == 4'h2) & f[0];
    rs = d - s - ci;
    case (op)
      4'h0: tk = (d == s);
      4'h4: tk = !s[b];
      4'h5: tk = s[b];
      4'h6: tk = !o[16 + b];
      4'h7: tk = o[16 + b];
      4'h8: tk = f[b];
      4'h9: tk = !f[b];
      4'ha: tk = f[1];
      4'hb: tk = !f[1];
      4'hc: tk = f[0];
      4'hd, 4'he: tk = !f[0];
      default: ;
    endcase
    if (op inside {[4'h1:4'h3]}) begin
      nf[0] = {1'b0, d} < {1'b0, s} + ci;
      nf[1] = (rs == 8'h00) && (op != 4'h2 || f[1]);
      nf[2] = rs[7];
      sd = int'($signed(d)) - int'($signed(s)) - int'(ci);
      nf[3] = (sd < -128) || (sd > 127);
      nf[4] = nf[2] ^ nf[3];
      nf[5] = {1'b0, d[3:0]} < {1'b0, s[3:0]} + ci;
    end
    cy = !tk ? 2'h1 : (op >= 4'h8) ? 2'h2 : lg ? 2'h3 : 2'h2;
    return {tk, cy, nf, (op == 4'hf) ? p0
      : (tk && op >= 4'h8) ? p0 + {{9{k[6]}}, k} + 16'h1 : p0 + cy};
  endfunction
  task automatic run_op(input logic [3:0] op, input logic [31:0] r1, input logic [31:0] r2);
    logic [26:0] e;
    logic [31:0] v;
    logic [1:0] r;
    int n;
    wr(8'h04, {8'h00, r1[23:0]}, r);
    wr(8'h08, {24'h0, r2[7:0]}, r);
    wr(8'h0c, {16'h0, r2[31:16]}, r);
    e = model(op, r2[10:8], r1[30:24], r2[15], r1[23:0], r2[7:0], r2[31:16]);
    wr(8'h00, {15'h0, r2[15], 1'b0, r1[30:24], 1'b0, r2[10:8], op}, r);
    chk(r, 2'h0);
    n = 0;
    do begin
      @(posedge aclk);
      bound(n++);
    end while (ret_cyc < launch);
    chk(ret_cyc - launch, e[25:24] + 1);
    chk(pc, e[15:0]);
    chk(flags, e[23:16]);
    rd(8'h10, v, r);
    chk(v[9:8], e[25:24]);
    chk(v[2:0], {op == 4'hf, e[26], 1'b0});
    rd(8'h04, v, r);
    chk(v, {8'h00, r1[23:0]});
  endtask
  initial begin
    logic [31:0] v;
    logic [1:0] r;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h0c, v, r);
    chk(v, 32'h0);
    rd(8'h08, v, r);
    chk(v, 32'h0);
    rd(8'h14, v, r);
    chk({v[29:0], r}, 32'h2);
    wr(8'h10, 32'hffffffff, r);
    chk(r, 2'h0);
    wr(8'h14, 32'h0, r);
    chk(r, 2'h2);
    wstrb <= 4'h2;
    wr(8'h0c, 32'h0000abcd, r);
    wstrb <= 4'hf;
    rd(8'h0c, v, r);
    chk(v, 32'h0000ab00);
    for (int i = 0; i < 16; i++) run_op(i[3:0], rnd(), rnd());
    run_op(4'h8, 32'h40000000, 32'h123400ff);
    run_op(4'hc, 32'h3f000000, 32'hfff00001);
    run_op(4'h0, 32'h00000000, 32'h00018000);
    run_op(4'h2, 32'h00000505, 32'h00000002);
    repeat (150) begin
      v = rnd();
      run_op(v[3:0], rnd(), rnd());
    end
    // Reset in mid-run, then reset values again
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h0c, v, r);
    chk(v, {16'h0000, cbsu_pkg::PC_RST});
    rd(8'h08, v, r);
    chk(v, {24'h00_0000, cbsu_pkg::FLAG_RST});
    rd(8'h10, v, r);
    chk(v, 32'h0);
    complete_run();
  end
endmodule
bind cbsu_unit cbsu_unit_chk u_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .pc(pc), .core_flag_register(core_flag_register),
  .retire(retire));
`default_nettype wire
